// >>> usb_prot_pkg.sv
// Constants, register map and state encodings of the port protection control.
package usb_prot_pkg;

  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned CNT_W         = 23;
  localparam int unsigned BLANK_TIME_MS       = 2;
  localparam int unsigned RETRY_TIME_MS       = 100;
  localparam int unsigned RELEASE_TIME_MS     = 8;
  localparam int unsigned REV_BLANK_TIME_MS   = 2;
  localparam int unsigned DATA_OFF_TIME_NS    = 200;
  // Longest times round down, least times round up.
  localparam int unsigned BLANK_CYCLES =
    BLANK_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned RETRY_CYCLES =
    (RETRY_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_CYCLES =
    RELEASE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned REV_BLANK_CYCLES =
    REV_BLANK_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned DATA_OFF_CYCLES =
    DATA_OFF_TIME_NS / CLK_PERIOD_NS;

  // Synchroniser bit positions of the pin inputs.
  localparam int unsigned SYNC_W        = 12;
  localparam int unsigned IX_PWR_EN_N   = 0;
  localparam int unsigned IX_DATA_EN_N  = 1;
  localparam int unsigned IX_OV_CONN    = 2;
  localparam int unsigned IX_OV_DPOS    = 3;
  localparam int unsigned IX_OV_DNEG    = 4;
  localparam int unsigned IX_SHORT_LOW  = 5;
  localparam int unsigned IX_OVER_CUR   = 6;
  localparam int unsigned IX_REV_RISE   = 7;
  localparam int unsigned IX_REV_FALL   = 8;
  localparam int unsigned IX_THERMAL    = 9;
  localparam int unsigned IX_SUPPLY_OK  = 10;
  localparam int unsigned IX_FAULT_PIN  = 11;
  // Enables and the released fault pin idle high, comparators idle low.
  localparam logic [11:0] SYNC_RESET    = 12'h0_803;

  // Register map, byte addresses.
  localparam logic [11:0] CTRL_OFFSET   = 12'h0_000;
  localparam logic [11:0] STATUS_OFFSET = 12'h0_004;
  localparam int unsigned CTRL_FORCE_OFF_BIT = 0;
  localparam logic        CTRL_RESET    = 1'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Status register field positions.
  localparam int unsigned ST_POWER_ON   = 0;
  localparam int unsigned ST_DATA_ON    = 1;
  localparam int unsigned ST_SHORT      = 2;
  localparam int unsigned ST_OC_LO      = 3;
  localparam int unsigned ST_REVERSE    = 5;
  localparam int unsigned ST_OVER_VOLT  = 6;
  localparam int unsigned ST_THERMAL    = 7;
  localparam int unsigned ST_FAULT      = 8;
  localparam int unsigned ST_FAULT_PIN  = 9;

  // Over-current hiccup states.
  typedef enum logic [1:0] {
    OC_IDLE    = 2'b00,
    OC_BLANK   = 2'b01,
    OC_OFF     = 2'b10,
    OC_RECOVER = 2'b11
  } oc_state_t;

endpackage : usb_prot_pkg

// >>> usb_port_protection_control.sv
// Switch selection, fault sequencing and register slave of the port guard.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Data switch follows the data enable; the power enable reaches it only through connector over-voltage and short.
// - Enables low/low both on, low/high power, high/low data, high/high off.
// - Normal mode only when enabled, supplies good and no fault active.
// - Over-voltage on any protected pin turns all switches off, asserts fault.
// - When over-voltage clears, switches return and fault releases unaided.
// - Over-voltage on a disabled path is ignored; that path stays off.
// - Connector below short threshold while enabled: short mode, fault, fixed current.
// - Connector back above short threshold: normal operation, fault released.
// - Current above limit: over-current state, current held at limit, fault.
// - Over-current lasting the blanking time turns power off, then retries.
// - Retry without over-current releases fault; otherwise cycle repeats.
// - Reverse voltage held for the reverse blanking time asserts fault.
// - Reverse difference below falling threshold releases fault, normal again.
// - Over-temperature turns power and data off and drives fault low.
// - Fault output is the OR of all five fault conditions.
// - Data switch turns off within 200 ns of an over-voltage.
// - Fault and power off within 2 ms of over-current onset.
// - Power stays off at least 100 ms after an over-current shutoff.
// - Fault releases 8 ms after the retry ends if over-current is gone.
// - Internal clock times the intervals; fault pin is open drain.
module usb_port_protection_control #(
  parameter int unsigned BLANK_CNT     = usb_prot_pkg::BLANK_CYCLES,
  parameter int unsigned RETRY_CNT     = usb_prot_pkg::RETRY_CYCLES,
  parameter int unsigned RELEASE_CNT   = usb_prot_pkg::RELEASE_CYCLES,
  parameter int unsigned REV_BLANK_CNT = usb_prot_pkg::REV_BLANK_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Controller enables, active low.
  input  wire logic        power_path_enable_n,
  input  wire logic        data_path_enable_n,
  // Analog comparator results.
  input  wire logic        connector_power_ov,
  input  wire logic        connector_data_pos_ov,
  input  wire logic        connector_data_neg_ov,
  input  wire logic        connector_below_short,
  input  wire logic        over_current,
  input  wire logic        reverse_above_rising,
  input  wire logic        reverse_below_falling,
  input  wire logic        thermal_over,
  input  wire logic        supplies_ok,
  // Open-drain fault pin.
  input  wire logic        fault_out_n_in,
  output logic             fault_out_n_out,
  output logic             fault_out_n_oe_n,
  // Switch drivers.
  output logic             power_switch_on,
  output logic             data_switch_on,
  output logic             short_current_mode,
  output logic             current_limit_mode,
  // Register bus.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int unsigned W = usb_prot_pkg::CNT_W;
  localparam logic [W-1:0] BLANK_LAST   = W'(BLANK_CNT - 1);
  localparam logic [W-1:0] RETRY_LAST   = W'(RETRY_CNT - 1);
  localparam logic [W-1:0] RELEASE_LAST = W'(RELEASE_CNT - 1);
  localparam logic [W-1:0] REV_LAST     = W'(REV_BLANK_CNT - 1);

  typedef struct packed {
    logic [usb_prot_pkg::SYNC_W-1:0] sync1;
    logic [usb_prot_pkg::SYNC_W-1:0] sync2;
    usb_prot_pkg::oc_state_t         oc;
    logic [W-1:0]                    oc_cnt;
    logic [W-1:0]                    rev_cnt;
    logic                            rev_fault;
    logic                            force_off;
    logic                            power_on;
    logic                            data_on;
    logic                            short_mode;
    logic                            limit_mode;
    logic                            fault_drv;
    logic                            fault_pin_out;
    logic                            awready;
    logic                            wready;
    logic                            aw_got;
    logic                            w_got;
    logic [11:0]                     awaddr;
    logic [31:0]                     wdata;
    logic                            wstrb0;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            arready;
    logic                            rvalid;
    logic [1:0]                      rresp;
    logic [31:0]                     rdata;
  } state_t;

  state_t s;
  state_t next_s;

  // Returns 1 for the control register, 2 for status, 0 for unmapped.
  function automatic logic [1:0] reg_select(input logic [11:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr[11:2] == usb_prot_pkg::CTRL_OFFSET[11:2]) begin
      sel = 2'h1;
    end else if (addr[11:2] == usb_prot_pkg::STATUS_OFFSET[11:2]) begin
      sel = 2'h2;
    end
    return sel;
  endfunction : reg_select

  logic [usb_prot_pkg::SYNC_W-1:0] pins;
  logic power_req;
  logic data_req;
  logic ov_hit;
  logic thermal;
  logic short_hit;
  logic oc_fault;
  logic fault_any;
  logic [31:0] status_word;

  always_comb begin
    pins = s.sync2;
    // Enables act only with good supplies and no software override.
    power_req = ~pins[usb_prot_pkg::IX_PWR_EN_N]
                & pins[usb_prot_pkg::IX_SUPPLY_OK] & ~s.force_off;
    data_req  = ~pins[usb_prot_pkg::IX_DATA_EN_N]
                & pins[usb_prot_pkg::IX_SUPPLY_OK] & ~s.force_off;
    thermal = pins[usb_prot_pkg::IX_THERMAL];
    // Over-voltage counts only on a path that is enabled.
    ov_hit = (power_req & pins[usb_prot_pkg::IX_OV_CONN])
             | (data_req & (pins[usb_prot_pkg::IX_OV_DPOS]
                            | pins[usb_prot_pkg::IX_OV_DNEG]));
    short_hit = power_req & pins[usb_prot_pkg::IX_SHORT_LOW]
                & ~ov_hit & ~thermal;
    // Over-current and reverse faults come from registered state, so they
    // reach the pin one clock after the level causes do; one 25 ns cycle is
    // nothing against limits counted in milliseconds.
    oc_fault = (s.oc != usb_prot_pkg::OC_IDLE);
    fault_any = ov_hit | oc_fault | short_hit | s.rev_fault
                | thermal;
    status_word = 32'h0000_0000;
    status_word[usb_prot_pkg::ST_POWER_ON]  = s.power_on;
    status_word[usb_prot_pkg::ST_DATA_ON]   = s.data_on;
    status_word[usb_prot_pkg::ST_SHORT]     = s.short_mode;
    status_word[usb_prot_pkg::ST_OC_LO +: 2] = s.oc;
    status_word[usb_prot_pkg::ST_REVERSE]   = s.rev_fault;
    status_word[usb_prot_pkg::ST_OVER_VOLT] = ov_hit;
    status_word[usb_prot_pkg::ST_THERMAL]   = thermal;
    status_word[usb_prot_pkg::ST_FAULT]     = s.fault_drv;
    status_word[usb_prot_pkg::ST_FAULT_PIN] =
      pins[usb_prot_pkg::IX_FAULT_PIN];

    next_s = s;
    // The first stage feeds only the second stage.
    next_s.sync1 = {fault_out_n_in, supplies_ok, thermal_over,
                    reverse_below_falling, reverse_above_rising,
                    over_current, connector_below_short,
                    connector_data_neg_ov, connector_data_pos_ov,
                    connector_power_ov, data_path_enable_n,
                    power_path_enable_n};
    next_s.sync2 = s.sync1;

    // Hiccup sequencer, timed by the system clock counters.
    if (!power_req || ov_hit || thermal || short_hit) begin
      next_s.oc     = usb_prot_pkg::OC_IDLE;
      next_s.oc_cnt = '0;
    end else begin
      unique case (s.oc)
        usb_prot_pkg::OC_IDLE: begin
          next_s.oc_cnt = '0;
          if (pins[usb_prot_pkg::IX_OVER_CUR]) begin
            next_s.oc = usb_prot_pkg::OC_BLANK;
          end
        end
        usb_prot_pkg::OC_BLANK: begin
          if (!pins[usb_prot_pkg::IX_OVER_CUR]) begin
            next_s.oc     = usb_prot_pkg::OC_IDLE;
            next_s.oc_cnt = '0;
          end else if (s.oc_cnt == BLANK_LAST) begin
            next_s.oc     = usb_prot_pkg::OC_OFF;
            next_s.oc_cnt = '0;
          end else begin
            next_s.oc_cnt = s.oc_cnt + 1'b1;
          end
        end
        usb_prot_pkg::OC_OFF: begin
          if (s.oc_cnt == RETRY_LAST) begin
            next_s.oc     = usb_prot_pkg::OC_RECOVER;
            next_s.oc_cnt = '0;
          end else begin
            next_s.oc_cnt = s.oc_cnt + 1'b1;
          end
        end
        usb_prot_pkg::OC_RECOVER: begin
          if (pins[usb_prot_pkg::IX_OVER_CUR]) begin
            next_s.oc     = usb_prot_pkg::OC_BLANK;
            next_s.oc_cnt = '0;
          end else if (s.oc_cnt == RELEASE_LAST) begin
            next_s.oc     = usb_prot_pkg::OC_IDLE;
            next_s.oc_cnt = '0;
          end else begin
            next_s.oc_cnt = s.oc_cnt + 1'b1;
          end
        end
      endcase
    end

    // Reverse detection leaves the switches as they are.
    if (s.rev_fault) begin
      next_s.rev_cnt = '0;
      if (pins[usb_prot_pkg::IX_REV_FALL]) begin
        next_s.rev_fault = 1'b0;
      end
    end else if (power_req && pins[usb_prot_pkg::IX_REV_RISE]) begin
      if (s.rev_cnt == REV_LAST) begin
        next_s.rev_fault = 1'b1;
        next_s.rev_cnt   = '0;
      end else begin
        next_s.rev_cnt = s.rev_cnt + 1'b1;
      end
    end else begin
      next_s.rev_cnt = '0;
    end

    // A fault removed is followed by automatic return of the paths.
    next_s.power_on = power_req & ~ov_hit & ~thermal
                      & (s.oc != usb_prot_pkg::OC_OFF);
    // Data is one register behind the synchroniser, well inside 200 ns.
    next_s.data_on = data_req & ~ov_hit & ~thermal
                     & ~short_hit;
    next_s.short_mode = short_hit;
    next_s.limit_mode = (s.oc == usb_prot_pkg::OC_BLANK);
    next_s.fault_drv  = fault_any;
    next_s.fault_pin_out = 1'b0;

    // Write channel: address and data taken in either order.
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = usb_prot_pkg::RESP_OKAY;
      unique case (reg_select(s.awaddr))
        2'h1: begin
          if (s.wstrb0) begin
            next_s.force_off =
              s.wdata[usb_prot_pkg::CTRL_FORCE_OFF_BIT];
          end
        end
        2'h2: begin
          next_s.bresp = usb_prot_pkg::RESP_OKAY;
        end
        default: begin
          next_s.bresp = usb_prot_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_got & ~next_s.bvalid;

    // Read channel. Status is captured on the edge that takes the address,
    // so a level that changes while rvalid waits is not reflected.
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = usb_prot_pkg::RESP_OKAY;
      unique case (reg_select(s_axi_araddr))
        2'h1: next_s.rdata = {31'h0000_0000, s.force_off};
        2'h2: next_s.rdata = status_word;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = usb_prot_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = ~next_s.rvalid;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s               <= '0;
      s.sync1         <= usb_prot_pkg::SYNC_RESET;
      s.sync2         <= usb_prot_pkg::SYNC_RESET;
      s.oc            <= usb_prot_pkg::OC_IDLE;
      s.force_off     <= usb_prot_pkg::CTRL_RESET;
      // Ready outputs come up high so the first request is taken at once.
      s.awready       <= 1'b1;
      s.wready        <= 1'b1;
      s.arready       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Open drain: the enable is low while the pin is pulled low.
  assign fault_out_n_out    = s.fault_pin_out;
  assign fault_out_n_oe_n   = ~s.fault_drv;
  assign power_switch_on    = s.power_on;
  assign data_switch_on     = s.data_on;
  assign short_current_mode = s.short_mode;
  assign current_limit_mode = s.limit_mode;
  assign s_axi_awready      = s.awready;
  assign s_axi_wready       = s.wready;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_arready      = s.arready;
  assign s_axi_rvalid       = s.rvalid;
  assign s_axi_rresp        = s.rresp;
  assign s_axi_rdata        = s.rdata;

endmodule : usb_port_protection_control

`default_nettype wire

// >>> prot_chk.sv
// Checker of the port protection control, bound to its ports.
`timescale 1ns/10ps
`default_nettype none
module prot_chk #(
  parameter int unsigned BLANK_CNT = 20
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic srst,
  // Pins in.
  input  wire logic power_path_enable_n,
  input  wire logic data_path_enable_n,
  input  wire logic connector_power_ov,
  input  wire logic connector_data_pos_ov,
  input  wire logic connector_data_neg_ov,
  input  wire logic connector_below_short,
  input  wire logic thermal_over,
  input  wire logic supplies_ok,
  // Pins out.
  input  wire logic fault_out_n_oe_n,
  input  wire logic power_switch_on,
  input  wire logic data_switch_on,
  input  wire logic short_current_mode,
  input  wire logic current_limit_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // Pins need two sync stages and an output register, hence [*3].
  int unsigned blank_n;
  always_ff @(posedge clk) begin
    if (srst || !(current_limit_mode && power_switch_on)) begin
      blank_n <= 0;
    end else begin
      blank_n <= blank_n + 1;
    end
  end
  property p_ov_off;
    (connector_power_ov && !power_path_enable_n && supplies_ok) [*3] |=>
      !power_switch_on && !data_switch_on && !fault_out_n_oe_n;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("ov off");
  property p_data_ov;
    ((connector_data_pos_ov || connector_data_neg_ov) &&
      !data_path_enable_n && supplies_ok) [*3] |=>
      !data_switch_on && !fault_out_n_oe_n;
  endproperty
  a_data_ov: assert property (p_data_ov) else $error("data ov");
  property p_data_en;
    data_path_enable_n [*3] |=> !data_switch_on;
  endproperty
  a_data_en: assert property (p_data_en) else $error("data en");
  property p_supply;
    !supplies_ok [*3] |=> !power_switch_on && !data_switch_on;
  endproperty
  a_supply: assert property (p_supply) else $error("supply");
  property p_thermal;
    thermal_over [*3] |=>
      !power_switch_on && !data_switch_on && !fault_out_n_oe_n;
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal");
  property p_short;
    (connector_below_short && !power_path_enable_n && supplies_ok &&
      !thermal_over && !connector_power_ov) [*3] |=>
      short_current_mode && !fault_out_n_oe_n;
  endproperty
  a_short: assert property (p_short) else $error("short");
  property p_oc_fault;
    current_limit_mode |-> ##[0:1] !fault_out_n_oe_n;
  endproperty
  a_oc_fault: assert property (p_oc_fault) else $error("oc");
  property p_blank;
    blank_n <= BLANK_CNT;
  endproperty
  a_blank: assert property (p_blank) else $error("blank");
endmodule : prot_chk
bind usb_port_protection_control prot_chk #(.BLANK_CNT(BLANK_CNT)) chk_i (
  .clk(clk), .srst(srst), .power_path_enable_n(power_path_enable_n),
  .data_path_enable_n(data_path_enable_n),
  .connector_power_ov(connector_power_ov),
  .connector_data_pos_ov(connector_data_pos_ov),
  .connector_data_neg_ov(connector_data_neg_ov),
  .connector_below_short(connector_below_short),
  .thermal_over(thermal_over), .supplies_ok(supplies_ok),
  .fault_out_n_oe_n(fault_out_n_oe_n), .power_switch_on(power_switch_on),
  .data_switch_on(data_switch_on), .short_current_mode(short_current_mode),
  .current_limit_mode(current_limit_mode)
);
`default_nettype wire

// >>> host_ctrl.sv
// Controller model: drives the enables and reads the fault line.
`timescale 1ns/10ps
`default_nettype none
module host_ctrl (
  // Clock.
  input  wire logic clk,
  // Fault pin of the guard.
  input  wire logic fault_out_n_out,
  input  wire logic fault_out_n_oe_n,
  output logic      fault_level_n,
  // Enables to the guard.
  output logic      power_path_enable_n,
  output logic      data_path_enable_n
);
  // Released line floats up through the board pull-up.
  assign fault_level_n = fault_out_n_oe_n ? 1'b1 : fault_out_n_out;
  initial begin
    power_path_enable_n = 1'b1;
    data_path_enable_n  = 1'b1;
  end
  task automatic set_mode(input logic pwr_n, input logic dat_n);
    @(posedge clk);
    power_path_enable_n <= pwr_n;
    data_path_enable_n  <= dat_n;
  endtask : set_mode
endmodule : host_ctrl
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the port protection control.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int BLANK = 20, RETRY = 50, RELEASE = 30, REV = 20;
  localparam logic [11:0] CT = usb_prot_pkg::CTRL_OFFSET;
  localparam logic [11:0] ST = usb_prot_pkg::STATUS_OFFSET;
  localparam logic [1:0]  OK = usb_prot_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = usb_prot_pkg::RESP_SLVERR;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [8:0]  cmp = 9'h100;
  logic [3:0]  wstrb = 4'hF;
  logic [4:0]  outs;
  logic        pwr_n, dat_n, flt_in, flt_out;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n;
  always #12.5 clk = ~clk;
  usb_port_protection_control #(
    .BLANK_CNT(BLANK), .RETRY_CNT(RETRY), .RELEASE_CNT(RELEASE),
    .REV_BLANK_CNT(REV)
  ) DUT (
    .clk(clk), .srst(srst), .power_path_enable_n(pwr_n),
    .data_path_enable_n(dat_n), .connector_power_ov(cmp[0]),
    .connector_data_pos_ov(cmp[1]), .connector_data_neg_ov(cmp[2]),
    .connector_below_short(cmp[3]), .over_current(cmp[4]),
    .reverse_above_rising(cmp[5]), .reverse_below_falling(cmp[6]),
    .thermal_over(cmp[7]), .supplies_ok(cmp[8]),
    .fault_out_n_in(flt_in), .fault_out_n_out(flt_out),
    .fault_out_n_oe_n(outs[0]), .power_switch_on(outs[4]),
    .data_switch_on(outs[3]), .short_current_mode(outs[2]),
    .current_limit_mode(outs[1]), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  host_ctrl host (
    .clk(clk), .fault_out_n_out(flt_out), .fault_out_n_oe_n(outs[0]),
    .fault_level_n(flt_in), .power_path_enable_n(pwr_n),
    .data_path_enable_n(dat_n)
  );
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic see(input logic [4:0] e);
    chk("pins", 32'(outs), 32'(e));
  endtask : see
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic hang();
    n_errors++;
    end_sim();
  endtask : hang
  // One transfer per call; every valid is held until its ready is seen.
  task automatic axi(input logic we, input logic [11:0] a,
                     input logic [31:0] d, input logic [1:0] r);
    int k;
    @(posedge clk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= we;
    wvalid  <= we;
    bready  <= we;
    arvalid <= !we;
    rready  <= !we;
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid || rvalid) break;
    end
    if (k == 64) hang();
    bready <= 1'b0;
    rready <= 1'b0;
    chk("resp", 32'(we ? bresp : rresp), 32'(r));
    if (!we) chk("rdata", rdata, d);
  endtask : axi
  task automatic pin(input int i, input logic v);
    @(posedge clk);
    cmp[i] <= v;
    repeat (4) @(posedge clk);
  endtask : pin
  task automatic wait_bit(input int b, input logic v);
    for (n = 0; n < 400; n++) begin
      if (outs[b] === v) break;
      @(posedge clk);
    end
    if (n == 400) hang();
  endtask : wait_bit
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    see(5'h01);
    axi(1'b0, ST, 32'h0000_0200, OK);
    axi(1'b1, CT, 32'h0000_0001, OK);
    host.set_mode(1'b0, 1'b0);
    repeat (4) @(posedge clk);
    see(5'h01);
    axi(1'b0, CT, 32'h0000_0001, OK);
    axi(1'b1, CT, 32'h0000_0000, OK);
    wstrb <= 4'hE;
    axi(1'b1, CT, 32'h0000_0001, OK);
    wstrb <= 4'hF;
    axi(1'b1, ST, 32'h0000_0000, OK);
    axi(1'b1, 12'h0_010, 32'h0000_0000, ERR);
    axi(1'b0, 12'h0_010, 32'h0000_0000, ERR);
    repeat (4) @(posedge clk);
    axi(1'b0, ST, 32'h0000_0203, OK);
    $display("test registers done");
    for (int m = 3; m >= 0; m--) begin
      host.set_mode(m[1], m[0]);
      repeat (4) @(posedge clk);
      see({~m[1], ~m[0], 3'b001});
    end
    for (int i = 0; i < 3; i++) begin
      pin(i, 1'b1);
      see(5'h00);
      pin(i, 1'b0);
      see(5'h19);
    end
    host.set_mode(1'b1, 1'b0);
    pin(0, 1'b1);
    see(5'h09);
    pin(0, 1'b0);
    host.set_mode(1'b0, 1'b1);
    pin(1, 1'b1);
    see(5'h11);
    pin(1, 1'b0);
    host.set_mode(1'b0, 1'b0);
    $display("test overvoltage done");
    pin(3, 1'b1);
    chk("short", 32'(outs & 5'h0D), 32'h0000_0004);
    pin(3, 1'b0);
    see(5'h19);
    pin(7, 1'b1);
    see(5'h00);
    axi(1'b0, ST, 32'h0000_0180, OK);
    chk("drive", 32'(flt_out), 32'h0);
    pin(7, 1'b0);
    pin(8, 1'b0);
    see(5'h01);
    pin(8, 1'b1);
    see(5'h19);
    pin(5, 1'b1);
    see(5'h19);
    wait_bit(0, 1'b0);
    chk("rev", 32'(n + 4 >= REV && n <= REV), 32'h1);
    see(5'h18);
    pin(5, 1'b0);
    pin(6, 1'b1);
    @(posedge clk);
    see(5'h19);
    pin(6, 1'b0);
    $display("test faults done");
    pin(4, 1'b1);
    @(posedge clk);
    see(5'h1A);
    wait_bit(4, 1'b0);
    chk("blank", 32'(n <= BLANK), 32'h1);
    wait_bit(4, 1'b1);
    chk("retry", 32'(n >= RETRY), 32'h1);
    wait_bit(4, 1'b0);
    chk("again", 32'(outs[0]), 32'h0);
    pin(4, 1'b0);
    wait_bit(4, 1'b1);
    chk("held", 32'(outs[0]), 32'h0);
    wait_bit(0, 1'b1);
    chk("recv", 32'(n + 1 >= RELEASE && n <= RELEASE + 1), 32'h1);
    see(5'h19);
    $display("test overcurrent done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
